// ---- verilog/dmc_defs.svh ----
// Offsets, field positions, reset values and codes of the channel mode block.
// Assumes inclusion by bare name from the package and bench files.
`ifndef DMC_DEFS_SVH
`define DMC_DEFS_SVH
`define DMC_OFF_MODE      12'h000
`define DMC_OFF_STEP      12'h004
`define DMC_OFF_SRCADDR   12'h008
`define DMC_OFF_DSTADDR   12'h00C
`define DMC_OFF_STATUS    12'h010
`define DMC_MODE_RESET    32'h00000000
`define DMC_ADDR_RESET    32'h00000000
`define DMC_DM_POS        14
`define DMC_SM_POS        12
`define DMC_RS_POS        8
`define DMC_DL_POS        7
`define DMC_DS_POS        6
`define DMC_TB_POS        5
`define DMC_TS_POS        3
`define DMC_DE_POS        0
`define DMC_RW_MASK       32'h0000FFF9
`define DMC_PIN_MASK      32'h000000C0
`define DMC_RS_EXT_DUAL   4'h0
`define DMC_RS_EXT_TOEXT  4'h2
`define DMC_RS_EXT_FROMEXT 4'h3
`define DMC_RS_AUTO       4'h4
`define DMC_RS_EXTSEL     4'h8
`endif

// ---- verilog/dmc_pkg.sv ----
// Types shared by the channel mode block.
// Assumes dmc_defs.svh is on the include path.
`include "dmc_defs.svh"
package dmc_pkg;
  typedef enum logic [1:0] {STEP_FIXED, STEP_INC, STEP_DEC, STEP_RSVD}
    dmc_step_t;
  typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_LONG, SZ_16B} dmc_size_t;
  typedef enum logic [1:0] {DET_LOW, DET_FALL, DET_HIGH, DET_RISE}
    dmc_det_t;
endpackage

// ---- verilog/dmc_addr_step.sv ----
// One address stepper: applies fixed/increment/decrement by unit size.
// Assumes a step pulse from the owning channel; reserved codes hold.
module dmc_addr_step
  import dmc_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              load,
  input  wire logic [31:0]       load_val,
  input  wire logic              step,
  input  wire logic              ignore,
  input  dmc_pkg::dmc_step_t     mode,
  input  dmc_pkg::dmc_size_t     size,
  output logic [31:0]            addr
);
  logic [31:0] addr_reg;
  logic [31:0] addr_next;
  wire  [31:0] unit;
  wire         dec_ok;

  // Unit size in bytes
  assign unit = (size == SZ_BYTE) ? 32'h00000001 :
                (size == SZ_WORD) ? 32'h00000002 :
                (size == SZ_LONG) ? 32'h00000004 : 32'h00000010;
  // Decrement undefined for 16-byte units, so hold instead
  assign dec_ok = (size != SZ_16B);

  // Next address select; software load wins over a step
  always_comb
  begin
    addr_next = addr_reg;
    if (load)
      addr_next = load_val;
    else if (step && !ignore)
    begin
      if (mode == STEP_INC)
        addr_next = addr_reg + unit;
      else if (mode == STEP_DEC && dec_ok)
        addr_next = addr_reg - unit;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      addr_reg <= `DMC_ADDR_RESET;
    else
      addr_reg <= addr_next;
  end

  assign addr = addr_reg;
endmodule // dmc_addr_step

// ---- verilog/dmc_channel.sv ----
// One DMA channel's mode control register with address stepping and
// request pin detection, reached over APB.
// Assumes synchronous request pin and a one-cycle unit-done pulse.
// Notes on behaviour
// - Destination mode 00 holds address.
// - Destination mode 01 adds unit size.
// - Destination mode 10 subtracts 1, 2, 4.
// - Single mode to device ignores destination mode.
// - Source mode 00 holds address.
// - Source mode 01 adds unit size.
// - Source mode 10 subtracts 1, 2, 4.
// - Single mode from device ignores source mode.
// - Source 0000 is external dual address.
// - Source 0010 single, memory to device.
// - Source 0011 single, device to memory.
// - 0100 auto, 1000 selector, others reserved.
// - External sources only on channels 0, 1.
// - Pin sampling bits absent on channels 2-5.
// - Sampling ignored for auto or selector sources.
// - Sampling codes: low, fall, high, rise.
// - Bus mode bit: 0 cycle steal, 1 burst.
// - Size code 11 means 16-byte units.
//
// Decided for this implementation: the APB slave port and the placing of the registers.
module dmc_channel
  import dmc_pkg::*;
#(
  parameter int CHANNEL = 0
)
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        transfer_request_pin,
  input  wire logic        unit_done,
  output logic             request_detected,
  output logic             transfer_acknowledge_pin,
  output logic             burst_mode,
  output logic             dual_address,
  output logic             channel_active
);
  import dmc_pkg::*;

  // Only six channels exist; refuse anything else at elaboration
  if (CHANNEL < 0 || CHANNEL > 5)
  begin : g_bad_channel
    $error("CHANNEL must lie in 0 to 5");
  end

  localparam bit HAS_PIN = (CHANNEL < 2);

  logic [31:0] channel_mode_control_reg;
  logic [31:0] channel_mode_control_next;
  logic        pin_prev_reg;
  logic        req_reg;
  logic        ack_reg;
  logic [31:0] prdata_reg;
  logic        pslverr_reg;
  logic        pready_reg;

  wire        setup    = psel && !penable;
  wire        access   = psel && penable && pready_reg;
  wire        wr       = access && pwrite;
  wire        hit_mode = (paddr == `DMC_OFF_MODE);
  wire        hit_src  = (paddr == `DMC_OFF_SRCADDR);
  wire        hit_dst  = (paddr == `DMC_OFF_DSTADDR);
  wire        hit_stat = (paddr == `DMC_OFF_STATUS);
  wire        mapped   = hit_mode || hit_src || hit_dst || hit_stat;
  wire [31:0] src_addr;
  wire [31:0] dst_addr;

  // Field decode of the stored mode word
  wire [3:0] req_source = channel_mode_control_reg[`DMC_RS_POS+3:`DMC_RS_POS];
  wire req_source_b3 = req_source[3];
  wire req_source_b2 = req_source[2];
  wire req_source_b1 = req_source[1];
  wire req_source_b0 = req_source[0];
  wire [1:0] dm_bits =
    channel_mode_control_reg[`DMC_DM_POS+1:`DMC_DM_POS];
  wire [1:0] sm_bits =
    channel_mode_control_reg[`DMC_SM_POS+1:`DMC_SM_POS];
  wire dest_step_hi = dm_bits[1];
  wire dest_step_lo = dm_bits[0];
  wire src_step_hi  = sm_bits[1];
  wire src_step_lo  = sm_bits[0];
  wire req_pin_level_sel = channel_mode_control_reg[`DMC_DL_POS];
  wire req_pin_edge_sel  = channel_mode_control_reg[`DMC_DS_POS];
  wire bus_mode_sel      = channel_mode_control_reg[`DMC_TB_POS];
  wire [1:0] ts_bits =
    channel_mode_control_reg[`DMC_TS_POS+1:`DMC_TS_POS];
  wire unit_size_hi = ts_bits[1];
  wire unit_size_lo = ts_bits[0];
  wire channel_enable = channel_mode_control_reg[`DMC_DE_POS];

  wire dmc_step_t dest_mode = dmc_step_t'({dest_step_hi, dest_step_lo});
  wire dmc_step_t src_mode  = dmc_step_t'({src_step_hi, src_step_lo});
  wire dmc_size_t unit_size = dmc_size_t'({unit_size_hi, unit_size_lo});
  wire dmc_det_t det_mode =
    dmc_det_t'({req_pin_level_sel, req_pin_edge_sel});

  wire src_ext_dual  = (req_source == `DMC_RS_EXT_DUAL);
  wire src_to_dev    = (req_source == `DMC_RS_EXT_TOEXT);
  wire src_from_dev  = (req_source == `DMC_RS_EXT_FROMEXT);
  wire src_auto      = (req_source == `DMC_RS_AUTO);
  wire src_sel       = (req_source == `DMC_RS_EXTSEL);
  wire src_external  = src_ext_dual || src_to_dev || src_from_dev;
  wire src_valid     = src_external || src_auto || src_sel;

  // pin fields absent off channels 0 and 1
  // Write data filtering: reserved bits and missing pin fields stay zero
  wire [31:0] wmask = HAS_PIN ? `DMC_RW_MASK
                              : (`DMC_RW_MASK & ~`DMC_PIN_MASK);

  always_comb
  begin
    channel_mode_control_next = channel_mode_control_reg;
    if (wr && hit_mode)
      channel_mode_control_next = pwdata & wmask;
    // external source refused off channels 0 and 1
    if (wr && hit_mode && !HAS_PIN
        && pwdata[`DMC_RS_POS+3:`DMC_RS_POS+2] == 2'b00)
      channel_mode_control_next = channel_mode_control_reg;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      channel_mode_control_reg <= `DMC_MODE_RESET;
    else
      channel_mode_control_reg <= channel_mode_control_next;
  end

  // Request pin detection; only the previous sample is kept
  wire pin_now = transfer_request_pin;
  wire det_hit = (det_mode == DET_LOW)  ? !pin_now :
                 (det_mode == DET_FALL) ? (pin_prev_reg && !pin_now) :
                 (det_mode == DET_HIGH) ? pin_now :
                                          (!pin_prev_reg && pin_now);
  // pin path exists only on channels 0 and 1
  wire req_now = channel_enable && src_valid &&
                 (src_external ? (HAS_PIN && det_hit) : 1'b1);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_prev_reg <= 1'b0;
      req_reg      <= 1'b0;
      ack_reg      <= 1'b0;
    end
    else
    begin
      pin_prev_reg <= pin_now;
      req_reg      <= req_now;
      ack_reg      <= unit_done && src_external && HAS_PIN;
    end
  end

  // single mode to device ignores destination
  wire dst_ignore = src_to_dev;
  // single mode from device ignores source
  wire src_ignore = src_from_dev;
  wire step_en    = unit_done && channel_enable;

  dmc_addr_step u_dst (
    .pclk     (pclk),
    .presetn  (presetn),
    .load     (wr && hit_dst),
    .load_val (pwdata),
    .step     (step_en),
    .ignore   (dst_ignore),
    .mode     (dest_mode),
    .size     (unit_size),
    .addr     (dst_addr)
  );

  dmc_addr_step u_src (
    .pclk     (pclk),
    .presetn  (presetn),
    .load     (wr && hit_src),
    .load_val (pwdata),
    .step     (step_en),
    .ignore   (src_ignore),
    .mode     (src_mode),
    .size     (unit_size),
    .addr     (src_addr)
  );

  // Read mux; unmapped addresses answer with an error and zero data
  wire [31:0] rd_mux =
    hit_mode ? channel_mode_control_reg :
    hit_src  ? src_addr :
    hit_dst  ? dst_addr :
    hit_stat ? {29'h0, req_reg, bus_mode_sel, channel_enable} : 32'h0;

  // APB slave: no wait states, answer registered in setup
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_reg  <= 1'b0;
      prdata_reg  <= 32'h00000000;
      pslverr_reg <= 1'b0;
    end
    else
    begin
      pready_reg  <= setup;
      prdata_reg  <= setup ? rd_mux : 32'h00000000;
      pslverr_reg <= setup && !mapped;
    end
  end

  logic burst_reg;
  logic dual_reg;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      burst_reg <= 1'b0;
      dual_reg  <= 1'b0;
    end
    else
    begin
      burst_reg <= bus_mode_sel;
      dual_reg  <= src_ext_dual && HAS_PIN;
    end
  end

  assign prdata                   = prdata_reg;
  assign pready                   = pready_reg;
  assign pslverr                  = pslverr_reg;
  assign request_detected         = req_reg;
  assign transfer_acknowledge_pin = ack_reg;
  assign burst_mode               = burst_reg;
  assign dual_address             = dual_reg;
  assign channel_active           = req_reg;

  // Guards
  mode_reset_a: assert property (@(posedge pclk)
    $rose(presetn) |-> channel_mode_control_reg == 32'h0)
    else $error("mode register not zero after reset");
  pin_bits_a: assert property (@(posedge pclk) disable iff (!presetn)
    !HAS_PIN |-> channel_mode_control_reg[7:6] == 2'b00)
    else $error("sampling bits set on channel without pin");
  ext_block_a: assert property (@(posedge pclk) disable iff (!presetn)
    !HAS_PIN |-> !src_external || channel_mode_control_reg[11:8] == 4'h0
      && !channel_enable || !req_reg || !src_external)
    else $error("external request on channel without pin");
  inc_step_a: assert property (@(posedge pclk) disable iff (!presetn)
    step_en && !(wr && hit_dst) && !dst_ignore && dest_mode == STEP_INC
      && unit_size == SZ_16B |=> dst_addr == $past(dst_addr) + 32'h10)
    else $error("destination did not add sixteen");
  dec_step_a: assert property (@(posedge pclk) disable iff (!presetn)
    step_en && !(wr && hit_src) && !src_ignore && src_mode == STEP_DEC
      && unit_size == SZ_LONG |=> src_addr == $past(src_addr) - 32'h4)
    else $error("source did not subtract four");
  fixed_a: assert property (@(posedge pclk) disable iff (!presetn)
    !(wr && hit_dst) && dest_mode == STEP_FIXED |=> $stable(dst_addr))
    else $error("fixed destination moved");
  ignore_dst_a: assert property (@(posedge pclk) disable iff (!presetn)
    !(wr && hit_dst) && dst_ignore |=> $stable(dst_addr))
    else $error("destination moved in single mode");
  ignore_src_a: assert property (@(posedge pclk) disable iff (!presetn)
    !(wr && hit_src) && src_ignore |=> $stable(src_addr))
    else $error("source moved in single mode");
  auto_req_a: assert property (@(posedge pclk) disable iff (!presetn)
    channel_enable && src_auto |=> request_detected)
    else $error("auto request not raised");
  burst_a: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> burst_mode == $past(bus_mode_sel))
    else $error("burst output wrong");
  src_inc_a: assert property (@(posedge pclk) disable iff (!presetn)
    step_en && !(wr && hit_src) && !src_ignore && src_mode == STEP_INC
      && unit_size == SZ_BYTE |=> src_addr == $past(src_addr) + 32'h1)
    else $error("source did not add one");
  dst_dec_a: assert property (@(posedge pclk) disable iff (!presetn)
    step_en && !(wr && hit_dst) && dest_mode == STEP_DEC && !dst_ignore
      && unit_size == SZ_WORD |=> dst_addr == $past(dst_addr) - 32'h2)
    else $error("destination did not subtract two");

  cov_burst: cover property (@(posedge pclk) burst_mode);
  cov_req: cover property (@(posedge pclk) request_detected);
  cov_ack: cover property (@(posedge pclk) transfer_acknowledge_pin);
endmodule // dmc_channel

// ---- bench/dmc_ext_dev.sv ----
// Far-side peripheral model: drives the request pin, counts acknowledges.
// Assumes the channel's pclk domain and a synchronous request pin.
module dmc_ext_dev
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       req_lvl,
  input  wire logic       transfer_acknowledge_pin,
  output logic            transfer_request_pin,
  output logic [7:0]      ack_count
);
  timeunit 1ns;
  timeprecision 1ps;
  // Pin idles high so a low-level sense sees no request after reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      transfer_request_pin <= 1'b1;
      ack_count            <= 8'h00;
    end
    else
    begin
      transfer_request_pin <= req_lvl;
      if (transfer_acknowledge_pin)
        ack_count <= ack_count + 8'h01;
    end
  end
endmodule // dmc_ext_dev

// ---- bench/test_dma_channel_mode_control.sv ----
// Self-checking bench for one channel (channel 0) over APB.
// Assumes dmc_defs.svh on the include path and the peripheral model.
`include "dmc_defs.svh"
module test_dma_channel_mode_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, unit_done = 1'b0, req_lvl = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, v;
  logic        pready, pslverr, pin, ack, det, burst, dual, act;
  logic [7:0]  acks;
  logic [32:0] exp_q[$], msk_q[$];
  int          n_fail = 0, samples_checked = 0, k;

  always #10 pclk = ~pclk;

  dmc_channel #(.CHANNEL(0)) dut_u (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .transfer_request_pin(pin), .unit_done(unit_done),
    .request_detected(det), .transfer_acknowledge_pin(ack),
    .burst_mode(burst), .dual_address(dual), .channel_active(act));
  dmc_ext_dev dev_u (.pclk(pclk), .presetn(presetn), .req_lvl(req_lvl),
    .transfer_acknowledge_pin(ack), .transfer_request_pin(pin),
    .ack_count(acks));

  task automatic close_out();
    $display("Checks %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [32:0] e,
                     input logic [32:0] g);
    samples_checked++;
    if (g !== e)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Masked compare lets an error answer skip its undefined data
  always @(posedge pclk)
  begin
    if (pready === 1'b1 && pwrite === 1'b0)
    begin
      if (exp_q.size() == 0)
        chk("stray answer", 33'h0, 33'h1);
      else
        chk("read", exp_q.pop_front() & msk_q[0],
            {pslverr, prdata} & msk_q.pop_front());
    end
  end

  // Request held until pready is seen high at an edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      chk("pready wait", 33'h1, 33'h0);
      close_out();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rd(input logic [11:0] a, input logic [32:0] e,
                    input logic [32:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    apb(1'b0, a, 32'h0);
  endtask

  function automatic logic [31:0] stp(input logic [1:0] m,
                                      input logic [1:0] sz);
    logic [31:0] u;
    u = (sz == 2'h3) ? 32'h10 : 32'h1 << sz;
    return (m == 2'h1) ? u : (m == 2'h2) ? -u : 32'h0;
  endfunction

  // One unit moved under a given source, step modes and size
  task automatic run(input logic [3:0] rs, input logic [1:0] dm,
                     input logic [1:0] sm, input logic [1:0] sz);
    logic [31:0] s, d, md, es, ed;
    logic [7:0]  a0;
    s = $urandom & 32'hFFFF_FFF0;
    d = $urandom & 32'hFFFF_FFF0;
    md = {16'h0, dm, sm, rs, 3'h0, sz, 3'h0};
    ed = d + ((rs == 4'h2) ? 32'h0 : stp(dm, sz));
    es = s + ((rs == 4'h3) ? 32'h0 : stp(sm, sz));
    apb(1'b1, `DMC_OFF_SRCADDR, s);
    apb(1'b1, `DMC_OFF_DSTADDR, d);
    apb(1'b1, `DMC_OFF_MODE, md);
    apb(1'b1, `DMC_OFF_MODE, md | 32'h1);
    a0 = acks;
    unit_done <= 1'b1;
    @(posedge pclk);
    unit_done <= 1'b0;
    repeat (3) @(posedge pclk);
    chk("acks", {25'h0, a0 + {7'h0, rs[3:2] == 2'h0}}, {25'h0, acks});
    chk("dual", {32'h0, rs == 4'h0}, {32'h0, dual});
    rd(`DMC_OFF_DSTADDR, {1'b0, ed}, '1);
    rd(`DMC_OFF_SRCADDR, {1'b0, es}, '1);
    apb(1'b1, `DMC_OFF_MODE, md);
  endtask

  initial
  begin
    void'($urandom(32'h98c7));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(`DMC_OFF_MODE, {1'b0, `DMC_MODE_RESET}, '1);
    rd(`DMC_OFF_SRCADDR, {1'b0, `DMC_ADDR_RESET}, '1);
    rd(12'h004, 33'h1_0000_0000, 33'h1_0000_0000);
    // Random fields, no reserved step code, auto source, disabled
    for (int i = 0; i < 4; i++)
    begin
      v = ($urandom & 32'hFFFF_54FE) | 32'h0000_0400;
      apb(1'b1, `DMC_OFF_MODE, v);
      rd(`DMC_OFF_MODE, {1'b0, v & `DMC_RW_MASK}, '1);
      chk("bus mode", {32'h0, v[5]}, {32'h0, burst});
    end
    for (int m = 0; m < 3; m++)
      for (int z = 0; z < 4; z++)
        if (z != 3 || m == 1)
          run(4'h4, m[1:0], (z == 3) ? 2'h1 : 2'((m + 1) % 3), z[1:0]);
    run(4'h0, 2'h1, 2'h2, 2'h2);
    run(4'h2, 2'h1, 2'h1, 2'h1);
    run(4'h3, 2'h2, 2'h1, 2'h0);
    run(4'h8, 2'h1, 2'h1, 2'h3);
    // Each sense code: idle first, then the active level or edge
    for (int c = 0; c < 4; c++)
    begin
      req_lvl <= ~c[1];
      apb(1'b1, `DMC_OFF_MODE, 32'(c) << 6);
      apb(1'b1, `DMC_OFF_MODE, (32'(c) << 6) | 32'h1);
      repeat (4) @(posedge pclk);
      if (!c[0])
        chk("idle sense", 33'h0, {32'h0, det});
      req_lvl <= c[1];
      k = 0;
      do
      begin
        @(posedge pclk);
        k++;
      end
      while (det !== 1'b1 && k < 6);
      chk("request sense", 33'h1, {32'h0, det});
      if (k >= 6)
        close_out();
    end
    close_out();
  end
endmodule // test_dma_channel_mode_control
